// *** src/iospb_builder.sv ***
// legacy layout sample record builder with wishbone register slave
// Notes on behaviour
// RQ1 - only lines 0..3 convert, and only when their function is 2
// RQ2 - each conversion is a 10-bit value 0x000..0x3ff
// RQ3 - each analog result occupies two record bytes
// RQ4 - one reference select applies to every analog channel
// RQ5 - both pulse outputs hold a fixed duty from their own duty value
// RQ6 - nothing configured means no record is produced
// RQ7 - periodic and change records go to high:low destination address
// RQ8 - nonzero period samples on timer and on non-pin wake
// RQ9 - any masked digital input change produces a record
// RQ10 - a query samples at once and answers with the record
// RQ11 - periodic, change and query triggers coexist
// RQ12 - output format 2, the default, selects the legacy layout
// RQ13 - first byte carries the samples-before-send setting
// RQ14 - mask bits 0..8 digital, 9..12 analog, 13..15 zero
// RQ15 - digital word bits 0..8 give line levels, rest zero
// RQ16 - digital word left out when digital mask is zero
// RQ17 - analog results follow in ascending channel order
// RQ18 - no analog bytes when analog mask is zero
// RQ19 - functions 3, 4 and 5 enable digital sampling
// RQ20 - multi-byte fields go out high byte first
module iospb_builder #(
	parameter int unsigned CYC_PER_UNIT = iospb_pkg::CYC_PER_UNIT
) (
	input  logic        clk_sys,
	input  logic        rst_n,
	input  logic        wb_cyc_i,
	input  logic        wb_stb_i,
	input  logic        wb_we_i,
	input  logic [7:0]  wb_adr_i,
	input  logic [3:0]  wb_sel_i,
	input  logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic        wb_ack_o,
	input  logic [8:0]  gen_line_in,
	output logic [8:0]  gen_line_out,
	output logic [8:0]  gen_line_oe_n,
	input  logic        wake_evt,
	input  logic        wake_pin,
	output logic        adc_req,
	output logic [1:0]  adc_chan,
	output logic [1:0]  adc_ref_sel,
	input  logic        adc_done,
	input  logic [9:0]  adc_result,
	output logic        rec_valid,
	output logic [7:0]  rec_data,
	output logic        rec_first,
	output logic        rec_last,
	output logic        rec_reply,
	output logic [63:0] rec_dest,
	input  logic        rec_ready,
	output logic        pulse_output_0,
	output logic        pulse_output_1
);
	import iospb_pkg::*;

	// ***************************************************************
	// state
	// ***************************************************************
	typedef struct packed {
		logic                  ack;
		logic [31:0]           rdat;
		logic [1:0]            fmt;
		logic [1:0]            aref;
		logic [7:0]            sbs;
		logic [26:0]           func;
		logic [5:0]            pfunc;
		logic [9:0]            duty0;
		logic [9:0]            duty1;
		logic [15:0]           period;
		logic [8:0]            cdm;
		logic [31:0]           dsth;
		logic [31:0]           dstl;
		logic                  err;
		logic                  pend_dst;
		logic                  pend_qry;
		iospb_state_type       st;
		logic [1:0]            ch;
		logic                  areq;
		logic [8:0]            dm;
		logic [3:0]            am;
		logic [8:0]            dig;
		logic [3:0][9:0]       res;
		logic [16:0]           ucnt;
		logic [15:0]           pcnt;
		logic [12:0][7:0]      buff;
		logic [3:0]            len;
		logic [3:0]            idx;
		logic                  reply;
		logic                  rv;
		logic [7:0]            rd;
		logic                  rf;
		logic                  rl;
		logic [8:0]            lout;
		logic [8:0]            loe_n;
	} iospb_core_type;

	iospb_core_type r_r;
	iospb_core_type r_nxt;

	logic [8:0] dmask;
	logic [3:0] amask;
	logic [8:0] din_en;
	logic       any_cfg;
	logic       chg;

	// ***************************************************************
	// line masks
	// ***************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 9; gi++) begin : g_line
			assign dmask[gi]  = is_dig(r_r.func[gi*3 +: 3]); // RQ19
			assign din_en[gi] = (r_r.func[gi*3 +: 3] == FN_DIN);
			if (gi < 4) begin : g_adc
				assign amask[gi] = (r_r.func[gi*3 +: 3] == FN_ADC); // RQ1
			end
		end
	endgenerate

	assign any_cfg = (|dmask) || (|amask);
	iospb_change_det u_chg (.clk_sys(clk_sys), .rst_n(rst_n), .din(gen_line_in),
		.mask(r_r.cdm & din_en), .changed(chg));
	iospb_pulse_gen u_pulse0 (.clk_sys(clk_sys), .rst_n(rst_n),
		.enable(r_r.pfunc[2:0] == FN_ADC), .duty(r_r.duty0), .pulse_out(pulse_output_0)); // RQ5
	iospb_pulse_gen u_pulse1 (.clk_sys(clk_sys), .rst_n(rst_n),
		.enable(r_r.pfunc[PF_LINE11_LSB +: 3] == FN_ADC), .duty(r_r.duty1),
		.pulse_out(pulse_output_1)); // RQ5

	// ***************************************************************
	// next state
	// ***************************************************************
	logic             wr;
	logic             qry_wr;
	logic             tick;
	logic             wake_ok;
	logic [15:0]      mask16;
	logic [12:0][7:0] abuf;
	logic [3:0]       p;
	logic             ok;
	logic [31:0]      wm;

	always_comb begin
		r_nxt   = r_r;
		wr      = wb_cyc_i && wb_stb_i && wb_we_i && !r_r.ack;
		qry_wr  = wr && (wb_adr_i == OFS_CMD) && wb_sel_i[0] && wb_dat_i[CMD_QUERY_BIT];
		tick    = 1'b0;
		wake_ok = (r_r.period != 16'h0000) && wake_evt && !wake_pin; // RQ8
		ok      = any_cfg && (r_r.fmt == FMT_LEGACY); // RQ6 RQ12
		// record assembly
		mask16  = {3'h0, r_r.am, r_r.dm}; // RQ14
		abuf    = '0;
		abuf[0] = r_r.sbs; // RQ13
		abuf[1] = mask16[15:8]; // RQ20
		abuf[2] = mask16[7:0];
		p       = 4'h3;
		if (|r_r.dm) begin // RQ16
			abuf[3] = {7'h00, r_r.dig[8]}; // RQ15
			abuf[4] = r_r.dig[7:0];
			p       = 4'h5;
		end
		for (int k = 0; k < 4; k++) begin
			if (r_r.am[k]) begin // RQ17 RQ18
				abuf[p]           = {6'h00, r_r.res[k][9:8]}; // RQ3 RQ20
				abuf[4'(p + 4'h1)] = r_r.res[k][7:0];
				p                 = 4'(p + 4'h2);
			end
		end

		// bus slave
		r_nxt.ack = wb_cyc_i && wb_stb_i && !r_r.ack;
		case (wb_adr_i)
			OFS_CTRL:  r_nxt.rdat = {16'h0000, r_r.sbs, 4'h0, r_r.aref, r_r.fmt};
			OFS_FUNC:  r_nxt.rdat = {5'h00, r_r.func};
			OFS_PFUNC: r_nxt.rdat = {26'h0000000, r_r.pfunc};
			OFS_DUTY:  r_nxt.rdat = {6'h00, r_r.duty1, 6'h00, r_r.duty0};
			OFS_IOCFG: r_nxt.rdat = {7'h00, r_r.cdm, r_r.period};
			OFS_DSTH:  r_nxt.rdat = r_r.dsth;
			OFS_DSTL:  r_nxt.rdat = r_r.dstl;
			OFS_CMD:   r_nxt.rdat = {30'h00000000, r_r.err, r_r.st != ST_IDLE};
			default:   r_nxt.rdat = 32'h00000000;
		endcase
		wm = r_nxt.rdat;
		for (int b = 0; b < 4; b++) begin
			if (wb_sel_i[b]) begin
				wm[b*8 +: 8] = wb_dat_i[b*8 +: 8];
			end
		end
		if (wr) begin
			case (wb_adr_i)
				OFS_CTRL: begin
					r_nxt.fmt  = wm[CTRL_FMT_LSB +: 2];
					r_nxt.aref = wm[CTRL_AREF_LSB +: 2]; // RQ4
					r_nxt.sbs  = wm[CTRL_SBS_LSB +: 8];
				end
				OFS_FUNC:  r_nxt.func  = wm[26:0];
				OFS_PFUNC: r_nxt.pfunc = wm[5:0];
				OFS_DUTY: begin
					r_nxt.duty0 = wm[9:0];
					r_nxt.duty1 = wm[DUTY1_LSB +: 10];
				end
				OFS_IOCFG: begin
					r_nxt.period = wm[15:0];
					r_nxt.cdm    = wm[IOCFG_CDM_LSB +: 9];
				end
				OFS_DSTH: r_nxt.dsth = wm;
				OFS_DSTL: r_nxt.dstl = wm;
				OFS_CMD: begin
					if (wb_sel_i[0] && wb_dat_i[CMD_ERRC_BIT]) begin
						r_nxt.err = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// periodic timer
		if (r_r.period == 16'h0000) begin
			r_nxt.ucnt = 17'h00000;
			r_nxt.pcnt = 16'h0000;
		end else if (r_r.ucnt == 17'(CYC_PER_UNIT - 1)) begin
			r_nxt.ucnt = 17'h00000;
			if (r_r.pcnt >= r_r.period - 16'h0001) begin
				r_nxt.pcnt = 16'h0000;
				tick       = 1'b1; // RQ8
			end else begin
				r_nxt.pcnt = r_r.pcnt + 16'h0001;
			end
		end else begin
			r_nxt.ucnt = r_r.ucnt + 17'h00001;
		end

		// line drive for output functions
		for (int i = 0; i < 9; i++) begin
			r_nxt.lout[i]  = (r_r.func[i*3 +: 3] == FN_DHI);
			r_nxt.loe_n[i] = !is_drv(r_r.func[i*3 +: 3]);
		end

		// sequencer
		case (r_r.st)
			ST_IDLE: begin
				if (r_r.pend_qry || r_r.pend_dst) begin
					r_nxt.reply = r_r.pend_qry;
					r_nxt.dm    = dmask;
					r_nxt.am    = amask;
					r_nxt.dig   = gen_line_in & dmask; // RQ15
					r_nxt.ch    = 2'h0;
					if (r_r.pend_qry) begin
						r_nxt.pend_qry = 1'b0;
						r_nxt.err      = !ok;
					end else begin
						r_nxt.pend_dst = 1'b0;
					end
					if (ok) begin
						r_nxt.st = ST_CONV; // RQ10
					end
				end
			end
			ST_CONV: begin
				if (r_r.am[r_r.ch] && !r_r.areq) begin
					r_nxt.areq = 1'b1; // RQ1
				end else if (!r_r.am[r_r.ch] || adc_done) begin
					if (r_r.am[r_r.ch]) begin
						r_nxt.res[r_r.ch] = adc_result; // RQ2
					end
					r_nxt.areq = 1'b0;
					r_nxt.ch   = r_r.ch + 2'h1;
					if (r_r.ch == 2'h3) begin
						r_nxt.st = ST_SEND;
					end
				end
			end
			ST_SEND: begin
				if (!r_r.rv && r_r.idx == 4'h0) begin
					r_nxt.buff = abuf;
					r_nxt.len  = p;
					r_nxt.rv   = 1'b1;
					r_nxt.rd   = abuf[0];
					r_nxt.rf   = 1'b1;
					r_nxt.rl   = 1'b0;
				end else if (r_r.rv && rec_ready) begin
					r_nxt.rf = 1'b0;
					if (r_r.idx == r_r.len - 4'h1) begin
						r_nxt.rv  = 1'b0;
						r_nxt.rl  = 1'b0;
						r_nxt.idx = 4'h0;
						r_nxt.st  = ST_IDLE;
					end else begin
						r_nxt.idx = r_r.idx + 4'h1;
						r_nxt.rd  = r_r.buff[r_r.idx + 4'h1];
						r_nxt.rl  = (r_r.idx + 4'h2 == r_r.len);
					end
				end
			end
			default: r_nxt.st = ST_IDLE;
		endcase

		// triggers set after any clear
		if (tick || chg || wake_ok) begin
			r_nxt.pend_dst = 1'b1; // RQ7 RQ9 RQ11
		end
		if (qry_wr) begin
			r_nxt.pend_qry = 1'b1; // RQ10 RQ11
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r_r       <= '0;
			r_r.fmt   <= RST_FMT;
			r_r.aref  <= RST_AREF;
			r_r.sbs   <= RST_SBS;
			r_r.st    <= ST_IDLE;
			r_r.loe_n <= '1;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign wb_ack_o      = r_r.ack;
	assign wb_dat_o      = r_r.rdat;
	assign gen_line_out  = r_r.lout;
	assign gen_line_oe_n = r_r.loe_n;
	assign adc_req       = r_r.areq;
	assign adc_chan      = r_r.ch;
	assign adc_ref_sel   = r_r.aref; // RQ4
	assign rec_valid     = r_r.rv;
	assign rec_data      = r_r.rd;
	assign rec_first     = r_r.rf;
	assign rec_last      = r_r.rl;
	assign rec_reply     = r_r.reply;
	assign rec_dest      = {r_r.dsth, r_r.dstl}; // RQ7

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_adc_enabled_only: assert property (adc_req |-> r_r.am[adc_chan]) // RQ1
		else $error("conversion on disabled channel");
	a_idle_unconfigured: assert property (r_r.st == ST_IDLE && !any_cfg |=> r_r.st == ST_IDLE) // RQ6
		else $error("record started with nothing configured");
	a_count_first: assert property (rec_valid && rec_first |-> rec_data == r_r.sbs) // RQ13
		else $error("first byte not sample count");
	a_mask_high: assert property (rec_valid && r_r.idx == 4'h1 |-> rec_data == {3'h0, r_r.am, r_r.dm[8]}) // RQ14
		else $error("mask high byte wrong");
	a_len_layout: assert property (rec_valid |-> r_r.len == 4'(3 + ((|r_r.dm) ? 2 : 0) + 2 * $countones(r_r.am))) // RQ17
		else $error("record length wrong");
	a_timer_pend: assert property (tick |=> r_r.pend_dst) // RQ8
		else $error("timer expiry not pending");
	a_change_pend: assert property (chg |=> r_r.pend_dst) // RQ9
		else $error("change not pending");
	a_query_start: assert property (r_r.st == ST_IDLE && r_r.pend_qry && ok |=> r_r.st == ST_CONV && rec_reply) // RQ10
		else $error("query not answered");
	a_last_flag: assert property (rec_valid && rec_last |-> r_r.idx == r_r.len - 4'h1) // RQ20
		else $error("last flag misplaced");
	c_query_rec: cover property (rec_valid && rec_last && rec_reply && rec_ready);
	c_auto_rec: cover property (rec_valid && rec_last && !rec_reply && rec_ready);
	c_query_err: cover property (!r_r.err ##1 r_r.err);

endmodule : iospb_builder

// *** src/iospb_change_det.sv ***
// change detect over the selected digital inputs
module iospb_change_det (
	input  logic       clk_sys,
	input  logic       rst_n,
	input  logic [8:0] din,
	input  logic [8:0] mask,
	output logic       changed
);
	import iospb_pkg::*;

	typedef struct packed {
		logic [8:0] prev;
		logic       armed;
		logic       chg;
	} iospb_cd_type;

	iospb_cd_type cd_r;
	iospb_cd_type cd_nxt;

	always_comb begin
		cd_nxt       = cd_r;
		cd_nxt.prev  = din;
		cd_nxt.armed = 1'b1;
		cd_nxt.chg   = cd_r.armed && (|((din ^ cd_r.prev) & mask)); // RQ9
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cd_r <= '0;
		end else begin
			cd_r <= cd_nxt;
		end
	end

	assign changed = cd_r.chg;

	a_change_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cd_r.armed && |((din ^ cd_r.prev) & mask) |=> changed)
		else $error("masked input change missed"); // RQ9

endmodule : iospb_change_det

// *** src/iospb_pkg.sv ***
// constants, types and helpers shared by the sample record builder
package iospb_pkg;

	// ***************************************************************
	// register offsets (byte addresses)
	// ***************************************************************
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_FUNC  = 8'h04;
	localparam logic [7:0] OFS_PFUNC = 8'h08;
	localparam logic [7:0] OFS_DUTY  = 8'h0c;
	localparam logic [7:0] OFS_IOCFG = 8'h10;
	localparam logic [7:0] OFS_DSTH  = 8'h14;
	localparam logic [7:0] OFS_DSTL  = 8'h18;
	localparam logic [7:0] OFS_CMD   = 8'h1c;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int CTRL_FMT_LSB  = 0;
	localparam int CTRL_AREF_LSB = 2;
	localparam int CTRL_SBS_LSB  = 8;
	localparam int PF_LINE11_LSB = 3;
	localparam int DUTY1_LSB     = 16;
	localparam int IOCFG_CDM_LSB = 16;
	localparam int CMD_QUERY_BIT = 0;
	localparam int CMD_ERRC_BIT  = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ERR_BIT  = 1;

	// ***************************************************************
	// reset values and codes
	// ***************************************************************
	localparam logic [1:0] FMT_LEGACY = 2'h2;
	localparam logic [1:0] RST_FMT    = FMT_LEGACY;
	localparam logic [1:0] RST_AREF   = 2'h0;
	localparam logic [7:0] RST_SBS    = 8'h01;
	localparam logic [2:0] FN_ADC     = 3'h2;
	localparam logic [2:0] FN_DIN     = 3'h3;
	localparam logic [2:0] FN_DLO     = 3'h4;
	localparam logic [2:0] FN_DHI     = 3'h5;
	localparam logic [9:0] ADC_MAX    = 10'h3ff;

	// ***************************************************************
	// timing: sample period unit is one millisecond
	// ***************************************************************
	localparam int unsigned UNIT_NS       = 1000000;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CYC_PER_UNIT  = UNIT_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_SEND = 2'b11
	} iospb_state_type;

	function automatic logic is_dig(input logic [2:0] f);
		is_dig = (f == FN_DIN) || (f == FN_DLO) || (f == FN_DHI);
	endfunction : is_dig

	function automatic logic is_drv(input logic [2:0] f);
		is_drv = (f == FN_DLO) || (f == FN_DHI);
	endfunction : is_drv

endpackage : iospb_pkg

// *** src/iospb_pulse_gen.sv ***
// fixed duty pulse-width output
module iospb_pulse_gen (
	input  logic       clk_sys,
	input  logic       rst_n,
	input  logic       enable,
	input  logic [9:0] duty,
	output logic       pulse_out
);
	import iospb_pkg::*;

	typedef struct packed {
		logic [9:0] cnt;
		logic       out;
	} iospb_pg_type;

	iospb_pg_type pg_r;
	iospb_pg_type pg_nxt;

	always_comb begin
		pg_nxt     = pg_r;
		pg_nxt.cnt = (pg_r.cnt == ADC_MAX) ? 10'h000 : pg_r.cnt + 10'h001;
		pg_nxt.out = enable && (pg_r.cnt < duty); // RQ5
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pg_r <= '0;
		end else begin
			pg_r <= pg_nxt;
		end
	end

	assign pulse_out = pg_r.out;

	a_pulse_off_disabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!enable |=> !pulse_out) else $error("pulse active while disabled"); // RQ5

endmodule : iospb_pulse_gen

// *** tb/iospb_builder_tb.sv ***
// self-checking bench for the sample record builder
module iospb_builder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import iospb_pkg::*;

	logic        clk_sys  = 1'b0;
	logic        rst_n    = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i  = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, q;
	logic        wb_ack_o, adc_req, adc_done, rec_valid, rec_first, rec_last, rec_reply, rec_ready;
	logic [8:0]  pins_r   = 9'h000;
	logic [8:0]  gen_line_in, gen_line_out, gen_line_oe_n;
	logic        wake_evt = 1'b0;
	logic        wake_pin = 1'b0;
	logic [1:0]  adc_chan, adc_ref_sel;
	logic [9:0]  adc_result;
	logic [7:0]  rec_data;
	logic [63:0] rec_dest;
	logic        pulse_output_0, pulse_output_1;
	int          num_errors = 0;
	int          checked    = 0;

	always #5 clk_sys = ~clk_sys;
	assign gen_line_in = (gen_line_oe_n & pins_r) | (~gen_line_oe_n & gen_line_out);

	iospb_builder #(.CYC_PER_UNIT(10)) iospb_builder_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.gen_line_in(gen_line_in), .gen_line_out(gen_line_out), .gen_line_oe_n(gen_line_oe_n),
		.wake_evt(wake_evt), .wake_pin(wake_pin), .adc_req(adc_req), .adc_chan(adc_chan),
		.adc_ref_sel(adc_ref_sel), .adc_done(adc_done), .adc_result(adc_result),
		.rec_valid(rec_valid), .rec_data(rec_data), .rec_first(rec_first), .rec_last(rec_last),
		.rec_reply(rec_reply), .rec_dest(rec_dest), .rec_ready(rec_ready),
		.pulse_output_0(pulse_output_0), .pulse_output_1(pulse_output_1));

	iospb_partner iospb_partner_inst (.clk_sys(clk_sys), .rst_n(rst_n), .adc_req(adc_req),
		.adc_chan(adc_chan), .adc_ref_sel(adc_ref_sel), .adc_done(adc_done),
		.adc_result(adc_result), .rec_valid(rec_valid), .rec_data(rec_data),
		.rec_first(rec_first), .rec_last(rec_last), .rec_reply(rec_reply),
		.rec_dest(rec_dest), .rec_ready(rec_ready));

	// ********************************
	// shared tasks
	// ********************************
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic conclude();
		$display("mismatches %0d comparisons %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do begin
			@(posedge clk_sys);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic flush();
		repeat (100) @(posedge clk_sys);
		check("framing", iospb_partner_inst.frame_err, 1'b0);
		iospb_partner_inst.rx_q.delete();
		iospb_partner_inst.frames = 0;
	endtask : flush

	task automatic no_rec(input string what);
		repeat (80) @(posedge clk_sys);
		check(what, iospb_partner_inst.frames, 0);
	endtask : no_rec

	task automatic exp_rec(input string what, input int n, input logic [71:0] v,
		input logic rep);
		int k;
		k = 0;
		while (iospb_partner_inst.frames == 0 && k < 500) begin
			@(posedge clk_sys);
			k++;
		end
		check({what, " size"}, iospb_partner_inst.rx_q.size(), n);
		for (int i = 0; i < n; i++)
			check(what, iospb_partner_inst.rx_q[i], v[8*(n-1-i) +: 8]);
		check({what, " reply"}, iospb_partner_inst.rx_reply, rep);
		flush();
	endtask : exp_rec

	task automatic wake(input logic pin);
		@(posedge clk_sys);
		wake_pin <= pin;
		wake_evt <= 1'b1;
		@(posedge clk_sys);
		wake_evt <= 1'b0;
	endtask : wake

	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset();
		wb(0, OFS_CTRL, 0);
		check("ctrl reset", q, 32'h0000_0102);
		wb(0, 8'h40, 0);
		check("unmapped", q, 32'h0);
		check("oe reset", gen_line_oe_n, 9'h1ff);
		wb(1, OFS_CMD, 32'h1);
		no_rec("empty query");
		wb(0, OFS_CMD, 0);
		check("empty error", q[1], 1'b1);
		wb(1, OFS_CMD, 32'h2);
		wb(0, OFS_CMD, 0);
		check("error clear", q[1], 1'b0);
	endtask : t_reset

	task automatic t_mix();
		wb(1, OFS_CTRL, 32'h0000_030e);
		wb(1, OFS_FUNC, 32'h0402_b402);
		pins_r <= 9'h012;
		wb(1, OFS_CMD, 32'h1);
		exp_rec("mix", 9, 72'h03_1330_0030_03ff_0155, 1'b1);
		check("mix oe", gen_line_oe_n, 9'h0df);
		check("mix out", gen_line_out, 9'h020);
		check("mix ref", iospb_partner_inst.rx_ref, 2'h3);
	endtask : t_mix

	task automatic t_timer();
		wb(1, OFS_DSTH, 32'h0013_a200);
		wb(1, OFS_DSTL, 32'h4000_1234);
		wb(1, OFS_FUNC, 32'h0000_0010);
		wb(1, OFS_IOCFG, 32'h1);
		exp_rec("timer", 5, 72'h03_0400_02a5, 1'b0);
		check("dest", iospb_partner_inst.rx_dest, 64'h0013_a200_4000_1234);
		wb(1, OFS_IOCFG, 32'h0);
		flush();
	endtask : t_timer

	task automatic t_change();
		wb(1, OFS_FUNC, 32'h000c_0000);
		wb(1, OFS_IOCFG, 32'h0040_0000);
		flush();
		pins_r <= 9'h052;
		exp_rec("change", 5, 72'h03_0040_0040, 1'b0);
		wb(1, OFS_CMD, 32'h1);
		exp_rec("query", 5, 72'h03_0040_0040, 1'b1);
	endtask : t_change

	task automatic t_wake();
		wb(1, OFS_IOCFG, 32'h0040_03e8);
		flush();
		wake(1'b1);
		no_rec("pin wake");
		wake(1'b0);
		exp_rec("wake", 5, 72'h03_0040_0040, 1'b0);
		wb(1, OFS_IOCFG, 32'h0);
		flush();
	endtask : t_wake

	task automatic t_format();
		wb(1, OFS_CTRL, 32'h0000_0300);
		wb(1, OFS_CMD, 32'h1);
		no_rec("format 0");
		wb(0, OFS_CMD, 0);
		check("format error", q[1], 1'b1);
		wb(1, OFS_CTRL, 32'h0000_030e);
		wb(1, OFS_CMD, 32'h2);
	endtask : t_format

	task automatic t_pwm();
		int h0, h1;
		h0 = 0;
		h1 = 0;
		wb(1, OFS_PFUNC, 32'h12);
		wb(1, OFS_DUTY, 32'h0300_0100);
		repeat (1100) @(posedge clk_sys);
		repeat (1024) begin
			@(posedge clk_sys);
			h0 += pulse_output_0;
			h1 += pulse_output_1;
		end
		check("duty 0", h0, 256);
		check("duty 1", h1, 768);
	endtask : t_pwm

	initial begin
		repeat (50000) @(posedge clk_sys);
		num_errors++;
		conclude();
	end

	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_mix();
		t_timer();
		t_change();
		t_wake();
		t_format();
		t_pwm();
		conclude();
	end
endmodule : iospb_builder_tb

// *** tb/iospb_partner.sv ***
// converter and record sink model facing the sample record builder
module iospb_partner (
	input  logic        clk_sys,
	input  logic        rst_n,
	input  logic        adc_req,
	input  logic [1:0]  adc_chan,
	input  logic [1:0]  adc_ref_sel,
	output logic        adc_done,
	output logic [9:0]  adc_result,
	input  logic        rec_valid,
	input  logic [7:0]  rec_data,
	input  logic        rec_first,
	input  logic        rec_last,
	input  logic        rec_reply,
	input  logic [63:0] rec_dest,
	output logic        rec_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  rx_q[$];
	int          frames    = 0;
	int          cur       = 0;
	logic        frame_err = 1'b0;
	logic        rx_reply;
	logic [63:0] rx_dest;
	logic [1:0]  rx_ref;
	logic [2:0]  wait_r;
	logic [3:0]  tick_r;
	logic        held_r;
	logic [7:0]  hold_r;

	function automatic logic [9:0] conv_val(input logic [1:0] c);
		case (c)
			2'h0: conv_val = 10'h3ff;
			2'h1: conv_val = 10'h2a5;
			2'h2: conv_val = 10'h0ea;
			default: conv_val = 10'h155;
		endcase
	endfunction : conv_val

	// ********************************
	// converter, latency grows with channel
	// ********************************
	always @(posedge clk_sys) begin
		tick_r     <= tick_r + 4'h1;
		rec_ready  <= (tick_r[1:0] != 2'h3);
		adc_done   <= 1'b0;
		adc_result <= ~adc_result;
		if (!rst_n) begin
			wait_r     <= 3'h0;
			tick_r     <= 4'h0;
			rec_ready  <= 1'b0;
			adc_result <= 10'h000;
		end else if (adc_req && !adc_done) begin
			rx_ref <= adc_ref_sel;
			if (wait_r == {1'b0, adc_chan}) begin
				adc_done   <= 1'b1;
				adc_result <= conv_val(adc_chan);
				wait_r     <= 3'h0;
			end else begin
				wait_r <= wait_r + 3'h1;
			end
		end
	end

	// ********************************
	// sink, stalls every fourth cycle
	// ********************************
	always @(posedge clk_sys) begin
		held_r <= rst_n && rec_valid && !rec_ready;
		hold_r <= rec_data;
		if (held_r && (!rec_valid || rec_data !== hold_r))
			frame_err <= 1'b1;
		if (rst_n && rec_valid && rec_ready) begin
			if (rec_first !== (cur == 0))
				frame_err <= 1'b1;
			if (cur == 0) begin
				rx_reply <= rec_reply;
				rx_dest  <= rec_dest;
			end
			rx_q.push_back(rec_data);
			cur++;
			if (rec_last) begin
				frames++;
				cur = 0;
			end
		end
	end
endmodule : iospb_partner
